// File: testbench/fel_line_model.sv
// Far-end line transmitter: scrambles, then MLT-3 codes the bit stream
`timescale 1ns/1ps
`default_nettype none
module fel_line_model #(
	parameter logic [10:0] SEED = 11'h5a5 // Any nonzero start state
) (
	input wire logic clock_i, // Symbol clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic bit_i, // Unscrambled NRZ bit
	input wire logic scr_en_i, // Scrambling on
	output fel_pkg::fel_level_t level_o // Line level
);
	import fel_pkg::*;
	logic [10:0] lfsr;
	logic [1:0] ph;
	logic key;
	logic sb;
	assign key = lfsr[10] ^ lfsr[8];
	assign sb = bit_i ^ (scr_en_i & key);
	// Changes land on the falling edge so the receiver samples settled levels
	always_ff @(negedge clock_i) begin
		if (rst_i) begin
			lfsr <= SEED;
			ph <= 2'h0;
		end else begin
			lfsr <= {lfsr[9:0], key};
			ph <= ph + {1'b0, sb};
		end
	end
	assign level_o = ph == 2'h1 ? FEL_LVL_POS :
		ph == 2'h3 ? FEL_LVL_NEG : FEL_LVL_ZERO;
endmodule : fel_line_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the line coding path
`include "fel_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fel_pkg::*;
	localparam int HOLD = 300;
	localparam logic [4:0] DC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a,
		5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b,
		5'h1c, 5'h1d};
	localparam logic [4:0] CTL [5] = '{`FEL_CODE_J, `FEL_CODE_K,
		`FEL_CODE_I, `FEL_CODE_T, `FEL_CODE_R};
	logic clock_i = 0;
	logic rst_i = 1;
	logic tx_bit_i = 0;
	logic energy = 0;
	logic link = 0;
	logic bypass = 0;
	logic line_bit = 1;
	logic scr_en = 1;
	logic sd;
	logic locked;
	logic aligned;
	fel_level_t level;
	fel_pair_t pair;
	fel_nib_t nib;
	fel_nib_t q[$];
	int n_mismatch = 0;
	int checked = 0;
	always #5 clock_i = ~clock_i;
	fel_line_model line (.clock_i(clock_i), .rst_i(rst_i), .bit_i(line_bit),
		.scr_en_i(scr_en), .level_o(level));
	fel_line_coding #(.HOLD_CYCLES(HOLD)) dut (.clock_i(clock_i),
		.rst_i(rst_i), .tx_bit_i(tx_bit_i), .transmit_pair_outputs_o(pair),
		.rx_level_i(level), .rx_energy_i(energy),
		.rx_link_pulse_i(link), .bypass_i(bypass), .signal_detect_o(sd),
		.rx_nib_o(nib), .scr_locked_o(locked), .aligned_o(aligned));
	always @(negedge clock_i) if (nib.stb) q.push_back(nib);
	task automatic cmp1(input string s, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %b seen %b", s, e, g);
		end
	endtask : cmp1
	task automatic cmp4(input string s, input logic [3:0] e,
		input logic [3:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask : cmp4
	task automatic cmp_pair(input logic [1:0] e, input fel_pair_t g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] pair expected %b seen %b", e, g);
		end
	endtask : cmp_pair
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc
	// First bit on the line is the group's MSB
	task automatic grp(input logic [4:0] c);
		for (int i = 4; i >= 0; i--) begin
			@(negedge clock_i);
			line_bit <= c[i];
		end
	endtask : grp
	task automatic idles(input int n);
		repeat (n) grp(`FEL_CODE_I);
	endtask : idles
	task automatic t_tx;
		logic [9:0] b;
		logic [1:0] e [10];
		logic [1:0] ph;
		b = 10'b11_0111_1001;
		ph = `FEL_PHASE_RST;
		for (int k = 0; k < 10; k++) begin
			ph = ph + {1'b0, b[9 - k]};
			e[k] = ph == `FEL_PHASE_POS ? 2'b10 :
				ph == `FEL_PHASE_NEG ? 2'b01 : 2'b00;
		end
		for (int k = 0; k < 12; k++) begin
			@(negedge clock_i);
			tx_bit_i <= k < 10 ? b[9 - k] : 1'b0;
			if (k >= 2) cmp_pair(e[k - 2], pair);
		end
		$display("test tx done");
	endtask : t_tx
	task automatic t_sd;
		energy <= 1;
		cyc(2);
		cmp1("detect", 1, sd);
		link <= 1;
		cyc(2);
		cmp1("detect", 0, sd);
		energy <= 0;
		link <= 0;
		$display("test detect done");
	endtask : t_sd
	task automatic t_lock;
		// Line has idled since start; a fresh reset restarts the lock search
		rst_i <= 1;
		cyc(2);
		rst_i <= 0;
		idles(11);
		cmp1("locked", 0, locked);
		idles(6);
		cmp1("locked", 1, locked);
		idles(80);
		cmp1("locked", 1, locked);
		$display("test lock done");
	endtask : t_lock
	task automatic t_pkt;
		idles(12);
		q.delete();
		grp(`FEL_CODE_J);
		grp(`FEL_CODE_K);
		for (int i = 0; i < 16; i++) grp(DC[i]);
		cmp1("aligned", 1, aligned);
		grp(`FEL_CODE_T);
		grp(`FEL_CODE_R);
		idles(4);
		cmp1("count", 1, q.size() == 18);
		for (int i = 0; i < 2; i++) cmp4("pre", `FEL_NIB_PRE, q[i].data);
		cmp1("pre dv", 1, q[0].dv);
		for (int i = 0; i < 16; i++) cmp4("data", 4'(i), q[i + 2].data);
		cmp1("data er", 0, q[17].er);
		cmp1("end dv", 0, nib.dv);
		$display("test packet done");
	endtask : t_pkt
	task automatic t_ctl;
		for (int c = 0; c < 5; c++) begin
			idles(12);
			q.delete();
			grp(`FEL_CODE_J);
			grp(`FEL_CODE_K);
			grp(DC[5]);
			grp(CTL[c]);
			grp(DC[3]);
			grp(`FEL_CODE_T);
			grp(`FEL_CODE_R);
			idles(4);
			cmp1("ctl er", 1, q[3].er);
			cmp4("ctl data", `FEL_NIB_BAD, q[3].data);
			cmp4("prior data", 4'h5, q[2].data);
		end
		$display("test control done");
	endtask : t_ctl
	task automatic t_bad;
		idles(3);
		q.delete();
		grp(DC[4]);
		grp(DC[7]);
		idles(4);
		for (int i = 0; i < 2; i++) begin
			cmp1("bad er", 1, q[i].er);
			cmp1("bad dv", 0, q[i].dv);
			cmp4("bad data", `FEL_NIB_BAD, q[i].data);
		end
		cmp1("bad end er", 0, nib.er);
		$display("test bad start done");
	endtask : t_bad
	// A long packet of zero nibbles never gives 58 idle bits, so lock expires
	task automatic t_hold;
		idles(3);
		grp(`FEL_CODE_J);
		grp(`FEL_CODE_K);
		repeat (70) grp(DC[0]);
		cmp1("locked", 0, locked);
		grp(`FEL_CODE_T);
		grp(`FEL_CODE_R);
		idles(2);
		cmp1("aligned", 0, aligned);
		idles(18);
		cmp1("relocked", 1, locked);
		$display("test hold done");
	endtask : t_hold
	task automatic t_bypass;
		bypass <= 1;
		scr_en <= 0;
		idles(12);
		q.delete();
		grp(`FEL_CODE_J);
		grp(`FEL_CODE_K);
		grp(DC[9]);
		grp(`FEL_CODE_T);
		grp(`FEL_CODE_R);
		idles(4);
		cmp1("count", 1, q.size() == 3);
		cmp4("data", 4'h9, q[2].data);
		$display("test bypass done");
	endtask : t_bypass
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test
	initial begin
		cyc(20);
		rst_i <= 0;
		cyc(1);
		cmp_pair(2'b00, pair);
		cmp1("locked", 0, locked);
		cmp4("nib", 4'h0, nib.data);
		t_tx();
		t_sd();
		t_lock();
		t_pkt();
		t_ctl();
		t_bad();
		t_hold();
		t_bypass();
		end_of_test();
	end
	// Whole run is about 1900 cycles; this leaves wide margin
	initial begin
		#300000;
		n_mismatch++;
		end_of_test();
	end
endmodule : tb
`default_nettype wire

// File: verilog/fel_line_coding.sv
// Line coding path: NRZI/MLT-3 transmit tail, receive decode to nibbles
// Contract
// R1 - NRZI-encode only the serialised scrambled stream
// R2 - Split NRZI into two alternating one-streams
// R3 - Output is MLT-3 only, no binary mode
// R4 - Link pulses alone never raise signal detect
// R5 - Decode received MLT-3 levels into NRZI
// R6 - Convert NRZI to NRZ before descrambling
// R7 - Deliver received data as 5-bit symbols
// R8 - Descramble by XOR with identical local key
// R9 - Lock after 12 idle groups, output unaligned
// R10 - Lock starts a 722 us hold countdown
// R11 - 58 idle bit times restart the countdown
// R12 - Expiry drops lock, resets, reacquires
// R13 - Aligner takes descrambler or bypass data
// R14 - Align on J/K pair, fixed boundary after
// R15 - Lookup table turns groups into nibbles
// R16 - Start of stream is J/K after idles
// R17 - J/K becomes two 0101 nibbles, then data
// R18 - Stop on T/R or two idle groups
// R19 - Key from 11-bit closed-loop LFSR
// R20 - Control groups in data flag receive error
// R21 - Bad start: error, 1110 until two idles
// R22 - NRZI toggles on one, holds on zero
// R23 - MLT-3 steps plus zero minus zero on ones
// R24 - After lock loss, wait for lock and alignment
`include "fel_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fel_line_coding #(
	parameter int HOLD_CYCLES = `FEL_HOLD_TIME_US * `FEL_CLK_MHZ
) (
	input wire logic clock_i, // Symbol clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic tx_bit_i, // Serialised scrambled transmit bit
	output fel_pkg::fel_pair_t transmit_pair_outputs_o, // Driver streams
	input wire fel_pkg::fel_level_t rx_level_i, // Equalised MLT-3 level
	input wire logic rx_energy_i, // Receive energy above threshold
	input wire logic rx_link_pulse_i, // Activity is only NLP/FLP pulses
	input wire logic bypass_i, // Descrambler bypass
	output logic signal_detect_o, // Qualified signal detect
	output fel_pkg::fel_nib_t rx_nib_o, // Nibble strobe, valid, error, data
	output logic scr_locked_o, // Descrambler synchronised
	output logic aligned_o // Code-group alignment held
);
	import fel_pkg::*;

	localparam int HW = $clog2(HOLD_CYCLES + 1);
	localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYCLES - 1);
	localparam int LOCK_BITS = `FEL_LOCK_GROUPS * `FEL_GROUP_BITS;
	localparam logic [5:0] LOCK_LAST = 6'(LOCK_BITS - 1);
	localparam logic [5:0] IDLE_LAST = 6'(`FEL_IDLE_BITS - 1);
	localparam logic [2:0] GRP_LAST = 3'(`FEL_GROUP_BITS - 1);

	// A hold time shorter than two lock searches (2 * LOCK_BITS) is rejected as too small
	if (HOLD_CYCLES < 2 * LOCK_BITS) begin : g_hold_check
		$error("HOLD_CYCLES too small for the lock search");
	end

	function automatic logic [4:0] fel_decode(input logic [4:0] g);
		logic [4:0] r;
		r = {1'b0, `FEL_NIB_BAD};
		unique case (g)
			5'h1e: r = {1'b1, 4'h0};
			5'h09: r = {1'b1, 4'h1};
			5'h14: r = {1'b1, 4'h2};
			5'h15: r = {1'b1, 4'h3};
			5'h0a: r = {1'b1, 4'h4};
			5'h0b: r = {1'b1, 4'h5};
			5'h0e: r = {1'b1, 4'h6};
			5'h0f: r = {1'b1, 4'h7};
			5'h12: r = {1'b1, 4'h8};
			5'h13: r = {1'b1, 4'h9};
			5'h16: r = {1'b1, 4'ha};
			5'h17: r = {1'b1, 4'hb};
			5'h1a: r = {1'b1, 4'hc};
			5'h1b: r = {1'b1, 4'hd};
			5'h1c: r = {1'b1, 4'he};
			5'h1d: r = {1'b1, 4'hf};
			default: r = {1'b0, `FEL_NIB_BAD};
		endcase
		return r;
	endfunction : fel_decode

	logic tx_nrzi;
	logic tx_nrzi_d;
	logic [1:0] phase;
	logic [1:0] next_phase;
	fel_pair_t tx_pair;
	fel_level_t rx_lvl_d;
	logic rx_nrzi;
	logic rx_nrzi_d;
	logic rx_nrz;
	logic [10:0] lfsr;
	logic n_key;
	logic next_ud;
	logic scr_locked;
	logic [5:0] match_cnt;
	logic [5:0] ones_cnt;
	logic [HW-1:0] hold_cnt;
	logic hold_refresh;
	logic hold_expire;
	logic rx_ok;
	logic [9:0] sh;
	logic [4:0] grp;
	logic [4:0] dec;
	fel_rx_state_t state;
	logic idle_seen;
	logic [2:0] ssd_cnt;
	logic [2:0] grp_cnt;
	logic pre_pend;
	logic t_pend;
	logic i_pend;
	fel_nib_t rx_nib;
	logic aligned;

	// Transmit NRZI; there is no binary bypass of the MLT-3 stage
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tx_nrzi <= 1'b0;
			tx_nrzi_d <= 1'b0;
		end else begin
			if (tx_bit_i) begin
				tx_nrzi <= ~tx_nrzi; // R1 R22 R3
			end
			tx_nrzi_d <= tx_nrzi;
		end
	end

	// Each NRZI transition is a coded one and advances the MLT-3 phase
	assign next_phase = (tx_nrzi != tx_nrzi_d) ? phase + 2'h1 : phase; // R23

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			phase <= `FEL_PHASE_RST;
			tx_pair <= '0;
		end else begin
			phase <= next_phase;
			tx_pair.pos <= (next_phase == `FEL_PHASE_POS); // R2
			tx_pair.neg <= (next_phase == `FEL_PHASE_NEG); // R2
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			signal_detect_o <= 1'b0;
		end else begin
			signal_detect_o <= rx_energy_i & ~rx_link_pulse_i; // R4
		end
	end

	// Receive: level change means NRZI toggle, NRZI toggle means NRZ one
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rx_lvl_d <= FEL_LVL_ZERO;
			rx_nrzi <= 1'b0;
			rx_nrzi_d <= 1'b0;
			rx_nrz <= 1'b0;
		end else begin
			rx_lvl_d <= rx_level_i;
			rx_nrzi <= rx_nrzi ^ (rx_level_i != rx_lvl_d); // R5
			rx_nrzi_d <= rx_nrzi;
			rx_nrz <= rx_nrzi ^ rx_nrzi_d; // R6 R22
		end
	end

	assign n_key = lfsr[10] ^ lfsr[8]; // R19
	assign next_ud = bypass_i ? rx_nrz : (rx_nrz ^ n_key); // R8 R13
	assign hold_refresh = next_ud && (ones_cnt == IDLE_LAST);
	assign hold_expire = scr_locked && !bypass_i && (hold_cnt == '0) &&
		!hold_refresh;
	assign rx_ok = scr_locked | bypass_i;

	// While hunting, assume idle: the key is the inverted line bit
	always_ff @(posedge clock_i) begin
		if (rst_i || hold_expire) begin
			lfsr <= '0; // R12
			scr_locked <= 1'b0; // R12
			match_cnt <= '0;
		end else if (!scr_locked) begin
			lfsr <= {lfsr[9:0], ~rx_nrz};
			if (rx_nrz ^ n_key) begin
				match_cnt <= match_cnt + 6'h1;
				if (match_cnt == LOCK_LAST) begin
					scr_locked <= 1'b1; // R9
				end
			end else begin
				match_cnt <= '0;
			end
		end else begin
			lfsr <= {lfsr[9:0], n_key}; // R19
		end
	end

	// Hold timer stays preset while unlocked, so lock starts a full count
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			hold_cnt <= HOLD_LOAD;
			ones_cnt <= '0;
		end else begin
			if (!next_ud || hold_refresh) begin
				ones_cnt <= '0;
			end else begin
				ones_cnt <= ones_cnt + 6'h1;
			end
			if (!scr_locked || hold_refresh) begin
				hold_cnt <= HOLD_LOAD; // R10 R11
			end else if (hold_cnt != '0) begin
				hold_cnt <= hold_cnt - HW'(1); // R10
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sh <= '0;
		end else begin
			sh <= {sh[8:0], next_ud}; // R7 R9 R13
		end
	end

	assign grp = sh[4:0]; // R7
	assign dec = fel_decode(grp); // R15

	// Packet framing; lock loss forces a fresh hunt
	always_ff @(posedge clock_i) begin
		if (rst_i || !rx_ok) begin
			state <= FEL_HUNT; // R24
			idle_seen <= 1'b0;
			ssd_cnt <= '0;
			grp_cnt <= '0;
			pre_pend <= 1'b0;
			t_pend <= 1'b0;
			i_pend <= 1'b0;
			rx_nib <= '0;
		end else begin
			rx_nib.stb <= 1'b0;
			grp_cnt <= (grp_cnt == GRP_LAST) ? 3'h0 : grp_cnt + 3'h1; // R14
			unique case (state)
				FEL_HUNT: begin
					rx_nib.dv <= 1'b0;
					rx_nib.er <= 1'b0;
					if (sh == {`FEL_CODE_I, `FEL_CODE_I}) begin
						idle_seen <= 1'b1;
					end else if (!sh[0]) begin
						idle_seen <= 1'b0;
						if (idle_seen) begin
							state <= FEL_SSD; // R16
							ssd_cnt <= 3'h1;
						end
					end
				end
				FEL_SSD: begin
					ssd_cnt <= ssd_cnt + 3'h1;
					if (ssd_cnt == `FEL_SSD_SPAN) begin
						grp_cnt <= '0; // R14
						t_pend <= 1'b0;
						i_pend <= 1'b0;
						rx_nib.stb <= 1'b1;
						if (sh == {`FEL_CODE_J, `FEL_CODE_K}) begin
							state <= FEL_PKT; // R14 R16
							pre_pend <= 1'b1;
							rx_nib.dv <= 1'b1;
							rx_nib.er <= 1'b0;
							rx_nib.data <= `FEL_NIB_PRE; // R17
						end else begin
							state <= FEL_BAD; // R21
							rx_nib.dv <= 1'b0;
							rx_nib.er <= 1'b1;
							rx_nib.data <= `FEL_NIB_BAD;
						end
					end
				end
				FEL_PKT: begin
					if (pre_pend) begin
						pre_pend <= 1'b0;
						rx_nib.stb <= 1'b1;
						rx_nib.data <= `FEL_NIB_PRE; // R17
					end
					if (grp_cnt == GRP_LAST) begin
						i_pend <= (grp == `FEL_CODE_I);
						t_pend <= (grp == `FEL_CODE_T) && !t_pend;
						if (t_pend && grp == `FEL_CODE_R) begin
							state <= FEL_HUNT; // R18
							rx_nib.dv <= 1'b0;
							rx_nib.er <= 1'b0;
						end else if (i_pend && grp == `FEL_CODE_I) begin
							state <= FEL_HUNT; // R18
							idle_seen <= 1'b1;
							rx_nib.dv <= 1'b0;
							rx_nib.er <= 1'b0;
						end else if (grp == `FEL_CODE_T && !t_pend) begin
							rx_nib.er <= 1'b0;
						end else begin
							rx_nib.stb <= 1'b1; // R17
							// A stray T in the data field is reported as invalid
							rx_nib.data <= t_pend ? `FEL_NIB_BAD : dec[3:0]; // R15 R20
							rx_nib.er <= ~dec[4] | t_pend; // R20
						end
					end
				end
				FEL_BAD: begin
					if (grp_cnt == GRP_LAST) begin
						i_pend <= (grp == `FEL_CODE_I);
						if (i_pend && grp == `FEL_CODE_I) begin
							state <= FEL_HUNT; // R21
							idle_seen <= 1'b1;
							rx_nib.er <= 1'b0;
						end else begin
							rx_nib.stb <= 1'b1;
							rx_nib.er <= 1'b1; // R21
							rx_nib.data <= `FEL_NIB_BAD; // R21
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			aligned <= 1'b0;
		end else begin
			aligned <= rx_ok && (state == FEL_PKT || state == FEL_BAD); // R24
		end
	end

	assign transmit_pair_outputs_o = tx_pair;
	assign rx_nib_o = rx_nib;
	assign scr_locked_o = scr_locked;
	assign aligned_o = aligned;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	sequence s_jk_found;
		rx_ok && state == FEL_SSD && ssd_cnt == `FEL_SSD_SPAN &&
			sh == {`FEL_CODE_J, `FEL_CODE_K};
	endsequence
	sequence s_two_pre;
		(rx_nib.stb && rx_nib.data == `FEL_NIB_PRE && rx_nib.dv) ##1
			(rx_nib.stb && rx_nib.data == `FEL_NIB_PRE && rx_nib.dv);
	endsequence

	a_pair_exclusive: assert property ( // R2
		!(tx_pair.pos && tx_pair.neg))
		else $error("both driver streams high");
	a_mlt_step_one: assert property ( // R23
		tx_bit_i |-> ##2 (tx_pair != $past(tx_pair)))
		else $error("one bit did not step the output");
	a_mlt_hold_zero: assert property ( // R22
		!tx_bit_i |-> ##2 $stable(tx_pair))
		else $error("zero bit changed the output");
	a_sigdet_pulses: assert property ( // R4
		rx_link_pulse_i |=> !signal_detect_o)
		else $error("signal detect on link pulses");
	a_rx_level_one: assert property ( // R5
		(rx_level_i != rx_lvl_d) |-> ##2 rx_nrz)
		else $error("level change not decoded as one");
	a_rx_level_zero: assert property ( // R6
		(rx_level_i == rx_lvl_d) |-> ##2 !rx_nrz)
		else $error("steady level not decoded as zero");
	a_lock_count: assert property ( // R9
		$rose(scr_locked) |-> $past(match_cnt) == LOCK_LAST)
		else $error("lock without full idle run");
	a_hold_reload: assert property ( // R11
		(scr_locked && hold_refresh) |=> hold_cnt == HOLD_LOAD)
		else $error("idle run did not restart hold timer");
	a_hold_drop: assert property ( // R12
		(hold_expire && hold_cnt == '0) |=> !scr_locked && lfsr == '0)
		else $error("expired hold timer kept lock");
	a_preamble_pair: assert property ( // R17
		s_jk_found |=> s_two_pre)
		else $error("start pair not given as two preamble nibbles");
	a_bad_nibble: assert property ( // R21
		(state == FEL_BAD && rx_nib.stb) |-> rx_nib.data == `FEL_NIB_BAD &&
			rx_nib.er)
		else $error("bad start not reported");
	a_unlock_quiet: assert property ( // R24
		!rx_ok |=> !rx_nib.dv && state == FEL_HUNT)
		else $error("decoding continued without lock");
endmodule : fel_line_coding
`default_nettype wire

// File: verilog/fel_params.svh
// Constants for the fast ethernet line coding path
`ifndef FEL_PARAMS_SVH
`define FEL_PARAMS_SVH
`define FEL_CLK_MHZ 100
`define FEL_HOLD_TIME_US 722
`define FEL_LOCK_GROUPS 12
`define FEL_GROUP_BITS 5
`define FEL_IDLE_BITS 58
`define FEL_SSD_SPAN 3'h7
`define FEL_CODE_I 5'h1f
`define FEL_CODE_J 5'h18
`define FEL_CODE_K 5'h11
`define FEL_CODE_T 5'h0d
`define FEL_CODE_R 5'h07
`define FEL_NIB_PRE 4'h5
`define FEL_NIB_BAD 4'he
`define FEL_PHASE_RST 2'h3
`define FEL_PHASE_POS 2'h0
`define FEL_PHASE_NEG 2'h2
`endif

// File: verilog/fel_pkg.sv
// Types shared by the fast ethernet line coding path
`default_nettype none
package fel_pkg;
	typedef enum logic [1:0] {
		FEL_LVL_ZERO = 2'h0,
		FEL_LVL_POS = 2'h1,
		FEL_LVL_NEG = 2'h3
	} fel_level_t;
	typedef struct packed {
		logic pos;
		logic neg;
	} fel_pair_t;
	typedef struct packed {
		logic stb;
		logic dv;
		logic er;
		logic [3:0] data;
	} fel_nib_t;
	typedef enum logic [1:0] {
		FEL_HUNT = 2'h0,
		FEL_SSD = 2'h1,
		FEL_PKT = 2'h2,
		FEL_BAD = 2'h3
	} fel_rx_state_t;
endpackage : fel_pkg
`default_nettype wire
